// file: ebba_asserts.sv
// port checker for the binning unit
// assumes it is bound onto ebba_binning, single clock domain
`timescale 1ns/100ps
module ebba_asserts (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // watched ports
    input wire logic [1:0] compress_i,
    input wire logic [3:0] evt_valid_i,
    input wire logic [3:0] evt_ready_o,
    input wire logic [1:0] inc_valid_o,
    input wire ebba_pkg::ebba_inc_t [1:0] inc_data_o,
    input wire logic [1:0] inc_ready_i,
    input wire logic [1:0] idle_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // mode is per event, so only trusted once the pipe drained while compressed
    logic cmp_ok_ff;
    always_ff @(posedge mclk_i) cmp_ok_ff <= nrst_i && compress_i[0] && (cmp_ok_ff || idle_o[0]);
    sequence s_take0; evt_valid_i[0] && evt_ready_o[0]; endsequence
    sequence s_fresh0; s_take0 ##0 idle_o[0]; endsequence
    property p_rdy_drop0; s_take0 |=> !evt_ready_o[0]; endproperty
    a_rdy_drop0: assert property (p_rdy_drop0) else $error("ready stuck after take");
    property p_rdy_drop3; evt_valid_i[3] && evt_ready_o[3] |=> !evt_ready_o[3]; endproperty
    a_rdy_drop3: assert property (p_rdy_drop3) else $error("ready stuck after take");
    property p_hold0; inc_valid_o[0] && !inc_ready_i[0] |=> inc_valid_o[0] && $stable(inc_data_o[0]); endproperty
    a_hold0: assert property (p_hold0) else $error("increment dropped while stalled");
    property p_range0; cmp_ok_ff && inc_valid_o[0] |-> inc_data_o[0].idx <= 8'h1F; endproperty
    a_range0: assert property (p_range0) else $error("bin index above last bin");
    property p_lat0; s_fresh0 |=> !inc_valid_o[0] [*8]; endproperty
    a_lat0: assert property (p_lat0) else $error("increment too early");
    property p_busy1; inc_valid_o[1] |-> !idle_o[1]; endproperty
    a_busy1: assert property (p_busy1) else $error("idle with pending increment");
    property p_busy0; s_take0 |=> !idle_o[0]; endproperty
    a_busy0: assert property (p_busy0) else $error("idle after take");
    property p_back0; s_fresh0 ##0 !evt_valid_i[1] |-> ##2 evt_ready_o[0]; endproperty
    a_back0: assert property (p_back0) else $error("ready late on empty pipe");
endmodule : ebba_asserts

// file: ebba_binning.sv
// two-telescope event binning unit: arbiter, boundary compare pipeline, output buffer
// assumes front ends and counter logic share mclk_i and honour valid/ready
`timescale 1ns/100ps
`include "ebba_regs.svh"
module ebba_binning #(
    parameter logic [`EBBA_NSTORED*`EBBA_VAL_W-1:0] BOUND_INIT = `EBBA_BOUND_INIT
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // per-telescope mode, 1 = 32 bins
    input wire logic [`EBBA_NTEL-1:0] compress_i,
    // detector_front_end event inputs
    input wire logic [`EBBA_NFE-1:0] evt_valid_i,
    input wire logic [`EBBA_NFE-1:0][`EBBA_VAL_W-1:0] evt_data_i,
    output logic [`EBBA_NFE-1:0] evt_ready_o,
    // counter increment outputs
    output logic [`EBBA_NTEL-1:0] inc_valid_o,
    output ebba_pkg::ebba_inc_t [`EBBA_NTEL-1:0] inc_data_o,
    input wire logic [`EBBA_NTEL-1:0] inc_ready_i,
    // per telescope: nothing held, buffered or past the entry slot
    output logic [`EBBA_NTEL-1:0] idle_o
);

    // one search step: stops at first boundary not below the value
    function automatic ebba_pkg::ebba_stage_t ebba_step(
        input ebba_pkg::ebba_stage_t s,
        input logic [`EBBA_VAL_W-1:0] b,
        input logic [`EBBA_VAL_W-1:0] k
    );
        ebba_pkg::ebba_stage_t r;
        r = s;
        if (s.valid && !s.done && (s.value <= b)) begin
            r.idx = k;
            r.done = 1'b1;
        end
        return r;
    endfunction : ebba_step

    // entry slot: full mode passes the value, compressed presets last bin
    function automatic ebba_pkg::ebba_stage_t ebba_entry(
        input logic v,
        input logic src,
        input logic [`EBBA_VAL_W-1:0] d,
        input logic cmp
    );
        ebba_pkg::ebba_stage_t r;
        r.valid = v;
        r.src = src;
        r.value = d;
        r.done = ~cmp;
        r.idx = cmp ? `EBBA_LAST_BIN : d;
        return r;
    endfunction : ebba_entry

    genvar t;
    generate
        for (t = 0; t < `EBBA_NTEL; t++) begin : g_tel
            // front ends 2t and 2t+1 share this table
            // nets: each bit comes from its own slot instance
            wire [1:0] hold_v_ff;
            wire [1:0] nxt_hold_v;
            logic [1:0] gnt;
            wire [`EBBA_VAL_W-1:0] hold_d_ff [0:1];
            ebba_pkg::ebba_prio_t prio_ff;
            ebba_pkg::ebba_prio_t nxt_prio;
            // explicit boundaries only, indices 0..30
            logic [`EBBA_VAL_W-1:0] bound_ff [0:`EBBA_NSTORED-1];
            ebba_pkg::ebba_stage_t pipe_ff [0:`EBBA_NSTAGE-1];
            ebba_pkg::ebba_stage_t nxt_entry;
            // two-entry output buffer, head drives the port
            logic head_v_ff;
            logic tail_v_ff;
            ebba_pkg::ebba_inc_t head_ff;
            logic nxt_head_v;
            logic nxt_tail_v;
            ebba_pkg::ebba_inc_t last_inc;
            logic idle_ff;
            logic nxt_idle;
            logic [`EBBA_NSTAGE-1:0] busy;

            wire both = hold_v_ff[0] & hold_v_ff[1];
            wire pick1 = both ? (prio_ff == ebba_pkg::EBBA_PRIO_FE1) : hold_v_ff[1];
            wire last_v = pipe_ff[`EBBA_NSTAGE-1].valid;
            wire buf_in_rdy = ~tail_v_ff;
            // stall only when the last slot cannot leave; loses no word
            wire adv = ~last_v | buf_in_rdy;
            wire take = adv & (|hold_v_ff);
            wire push = adv & last_v;
            wire [`EBBA_VAL_W-1:0] sel_d = pick1 ? hold_d_ff[1] : hold_d_ff[0];

            assign gnt[0] = take & ~pick1;
            assign gnt[1] = take & pick1;
            assign nxt_prio = take ? (pick1 ? ebba_pkg::EBBA_PRIO_FE0 : ebba_pkg::EBBA_PRIO_FE1) : prio_ff;
            assign nxt_entry = ebba_entry(take, pick1, sel_d, compress_i[t]);
            assign last_inc.src = pipe_ff[`EBBA_NSTAGE-1].src;
            assign last_inc.idx = pipe_ff[`EBBA_NSTAGE-1].idx;

            // per-input holding slot; ready is registered so a slot takes 1 per 2 cycles
            genvar j;
            for (j = 0; j < 2; j++) begin : g_in
                ebba_slot ebba_slot_inst (
                    .mclk_i(mclk_i),
                    .nrst_i(nrst_i),
                    .evt_valid_i(evt_valid_i[2*t+j]),
                    .evt_data_i(evt_data_i[2*t+j]),
                    .evt_ready_o(evt_ready_o[2*t+j]),
                    .gnt_i(gnt[j]),
                    .hold_v_o(hold_v_ff[j]),
                    .hold_d_o(hold_d_ff[j]),
                    .nxt_hold_v_o(nxt_hold_v[j])
                );
            end

            // same design-time table for every telescope and particle type
            genvar b;
            for (b = 0; b < `EBBA_NSTORED; b++) begin : g_bound
                always_ff @(posedge mclk_i) begin
                    if (!nrst_i) begin
                        bound_ff[b] <= BOUND_INIT[b*`EBBA_VAL_W +: `EBBA_VAL_W];
                    end
                end
            end

            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    prio_ff <= ebba_pkg::EBBA_PRIO_FE0;
                end else begin
                    prio_ff <= nxt_prio;
                end
            end

            // entry slot
            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    pipe_ff[0] <= '0;
                end else if (adv) begin
                    pipe_ff[0] <= nxt_entry;
                end
            end

            // one boundary per stage, ascending; full mode passes through done
            genvar k;
            for (k = 0; k < `EBBA_NSTORED; k++) begin : g_cmp
                always_ff @(posedge mclk_i) begin
                    if (!nrst_i) begin
                        pipe_ff[k+1] <= '0;
                    end else if (adv) begin
                        pipe_ff[k+1] <= ebba_step(pipe_ff[k], bound_ff[k], 8'(k));
                    end
                end
            end

            // output buffer: a stalled counter side costs no word
            ebba_obuf ebba_obuf_inst (
                .mclk_i(mclk_i),
                .nrst_i(nrst_i),
                .push_i(push),
                .data_i(last_inc),
                .ready_i(inc_ready_i[t]),
                .head_v_o(head_v_ff),
                .head_o(head_ff),
                .tail_v_o(tail_v_ff),
                .nxt_head_v_o(nxt_head_v),
                .nxt_tail_v_o(nxt_tail_v)
            );

            // idle when nothing held, buffered or in flight past the entry slot
            genvar p;
            for (p = 0; p < `EBBA_NSTAGE; p++) begin : g_busy
                assign busy[p] = pipe_ff[p].valid;
            end
            assign nxt_idle = ~(|nxt_hold_v) & ~(|busy) & ~nxt_head_v & ~nxt_tail_v;

            always_ff @(posedge mclk_i) begin
                if (!nrst_i) begin
                    idle_ff <= 1'b1;
                end else begin
                    idle_ff <= nxt_idle;
                end
            end

            assign inc_valid_o[t] = head_v_ff;
            assign inc_data_o[t] = head_ff;
            assign idle_o[t] = idle_ff;
        end
    endgenerate

    // implicit 0 never needs a compare; implicit 255 is the preset last bin

endmodule : ebba_binning

// one event holding slot per front end
// ready is registered: one take every two cycles, which the shared
// pipe can still absorb since two slots alternate
module ebba_slot (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // front-end handshake
    input wire logic evt_valid_i,
    input wire logic [`EBBA_VAL_W-1:0] evt_data_i,
    output logic evt_ready_o,
    // towards the arbiter
    input wire logic gnt_i,
    output logic hold_v_o,
    output logic [`EBBA_VAL_W-1:0] hold_d_o,
    output logic nxt_hold_v_o
);
    logic hold_v_ff;
    logic rdy_ff;
    logic [`EBBA_VAL_W-1:0] hold_d_ff;
    wire cap = rdy_ff & evt_valid_i;
    wire nxt_hold_v = (hold_v_ff & ~gnt_i) | cap;

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            hold_v_ff <= 1'b0;
            rdy_ff <= 1'b0;
            hold_d_ff <= 8'h00;
        end else begin
            hold_v_ff <= nxt_hold_v;
            rdy_ff <= ~nxt_hold_v;
            if (cap) begin
                hold_d_ff <= evt_data_i;
            end
        end
    end

    assign evt_ready_o = rdy_ff;
    assign hold_v_o = hold_v_ff;
    assign hold_d_o = hold_d_ff;
    assign nxt_hold_v_o = nxt_hold_v;

endmodule : ebba_slot

// two-entry increment buffer; head drives the port
// tail only fills while the head waits, so a full tail means stall
module ebba_obuf (
    // clock and reset
    input wire logic mclk_i,
    input wire logic nrst_i,
    // from the last pipeline slot
    input wire logic push_i,
    input wire ebba_pkg::ebba_inc_t data_i,
    // towards counter logic
    input wire logic ready_i,
    output logic head_v_o,
    output ebba_pkg::ebba_inc_t head_o,
    // fill state for stall and idle logic
    output logic tail_v_o,
    output logic nxt_head_v_o,
    output logic nxt_tail_v_o
);
    logic head_v_ff;
    logic tail_v_ff;
    ebba_pkg::ebba_inc_t head_ff;
    ebba_pkg::ebba_inc_t tail_ff;
    logic nxt_head_v;
    logic nxt_tail_v;
    ebba_pkg::ebba_inc_t nxt_head;
    ebba_pkg::ebba_inc_t nxt_tail;
    wire pop = head_v_ff & ready_i;

    // head refilled from tail or directly from the pipe
    always_comb begin
        nxt_head_v = head_v_ff;
        nxt_head = head_ff;
        nxt_tail_v = tail_v_ff;
        nxt_tail = tail_ff;
        if (pop) begin
            nxt_head_v = tail_v_ff;
            nxt_head = tail_ff;
            nxt_tail_v = 1'b0;
        end
        if (push_i) begin
            if (!nxt_head_v) begin
                nxt_head_v = 1'b1;
                nxt_head = data_i;
            end else begin
                nxt_tail_v = 1'b1;
                nxt_tail = data_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!nrst_i) begin
            head_v_ff <= 1'b0;
            tail_v_ff <= 1'b0;
            head_ff <= '0;
            tail_ff <= '0;
        end else begin
            head_v_ff <= nxt_head_v;
            tail_v_ff <= nxt_tail_v;
            head_ff <= nxt_head;
            tail_ff <= nxt_tail;
        end
    end

    assign head_v_o = head_v_ff;
    assign head_o = head_ff;
    assign tail_v_o = tail_v_ff;
    assign nxt_head_v_o = nxt_head_v;
    assign nxt_tail_v_o = nxt_tail_v;

endmodule : ebba_obuf

// file: ebba_far.sv
// far side model: four front-end sources and two counter sinks
// assumes the bench queues values and changes stall_i after rising edges
`timescale 1ns/100ps
module ebba_far (
    // clock
    input wire logic mclk_i,
    // front-end side
    input wire logic [3:0] evt_ready_o,
    output logic [3:0] evt_valid_i,
    output logic [3:0][7:0] evt_data_i,
    // counter side
    input wire logic [1:0] inc_valid_o,
    input wire ebba_pkg::ebba_inc_t [1:0] inc_data_o,
    output logic [1:0] inc_ready_i,
    input wire logic [1:0] stall_i
);
    logic [7:0] evq [4][$];
    ebba_pkg::ebba_inc_t got [2][$];
    logic [3:0] tk = '0;
    initial begin
        evt_valid_i = '0;
        evt_data_i = '0;
        inc_ready_i = '0;
    end
    always @(posedge mclk_i) begin
        tk = evt_valid_i & evt_ready_o;
        for (int t = 0; t < 2; t++) begin
            if (inc_valid_o[t] && inc_ready_i[t]) begin
                got[t].push_back(inc_data_o[t]);
            end
        end
    end
    // idle data lines toggle so a stale word never looks valid
    always @(negedge mclk_i) begin
        inc_ready_i <= ~stall_i;
        for (int f = 0; f < 4; f++) begin
            if (tk[f]) begin
                void'(evq[f].pop_front());
            end
            evt_valid_i[f] <= evq[f].size() > 0;
            evt_data_i[f] <= evq[f].size() > 0 ? evq[f][0] : ~evt_data_i[f];
        end
    end
endmodule : ebba_far

// file: ebba_pkg.sv
// types shared by the event binning unit
// assumes ebba_regs.svh supplies the widths
`include "ebba_regs.svh"
package ebba_pkg;
    // one increment request towards counter logic
    typedef struct packed {
        logic src;
        logic [`EBBA_VAL_W-1:0] idx;
    } ebba_inc_t;

    // one slot of the comparison pipeline
    typedef struct packed {
        logic valid;
        logic done;
        logic src;
        logic [`EBBA_VAL_W-1:0] value;
        logic [`EBBA_VAL_W-1:0] idx;
    } ebba_stage_t;

    typedef enum logic {
        EBBA_PRIO_FE0,
        EBBA_PRIO_FE1
    } ebba_prio_t;
endpackage : ebba_pkg

// file: ebba_regs.svh
// constants of the event binning unit: widths, bin counts, table defaults
// assumes a single 50 MHz system clock and synchronous front-end handshakes
`ifndef EBBA_REGS_SVH
`define EBBA_REGS_SVH
`define EBBA_VAL_W 8
`define EBBA_NTEL 2
`define EBBA_NFE 4
`define EBBA_NBINS 32
`define EBBA_NSTORED 31
`define EBBA_NSTAGE 32
`define EBBA_LAST_BIN 8'h1F
`define EBBA_IMPL_LO 8'h00
`define EBBA_IMPL_HI 8'hFF
`define EBBA_BOUND_INIT 248'hF7EFE7DFD7CFC7BFB7AFA79F978F877F776F675F574F473F372F271F170F07
`endif

// file: tb_top.sv
// self-checking bench for the binning unit
// assumes partner ebba_far and checker ebba_asserts
`timescale 1ns/100ps
`include "ebba_regs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t got %h exp %h", $time, a, b); end end
module tb_top;
    localparam logic [247:0] BND = `EBBA_BOUND_INIT;
    logic mclk_i, nrst_i;
    logic [1:0] compress_i, inc_valid_o, inc_ready_i, idle_o, stall;
    logic [3:0] evt_valid_i, evt_ready_o;
    logic [3:0][7:0] evt_data_i;
    ebba_pkg::ebba_inc_t [1:0] inc_data_o;
    int miscompares, compares;
    logic [7:0] exq [4][$];
    ebba_binning ebba_binning_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .compress_i(compress_i),
        .evt_valid_i(evt_valid_i), .evt_data_i(evt_data_i), .evt_ready_o(evt_ready_o),
        .inc_valid_o(inc_valid_o), .inc_data_o(inc_data_o), .inc_ready_i(inc_ready_i), .idle_o(idle_o));
    ebba_far ebba_far_inst (.mclk_i(mclk_i), .evt_ready_o(evt_ready_o), .evt_valid_i(evt_valid_i),
        .evt_data_i(evt_data_i), .inc_valid_o(inc_valid_o), .inc_data_o(inc_data_o),
        .inc_ready_i(inc_ready_i), .stall_i(stall));
    function automatic logic [7:0] want(input logic m, input logic [7:0] v);
        if (!m) return v;
        for (int k = 0; k < 31; k++) begin
            if (v <= BND[8*k+:8]) return 8'(k);
        end
        return 8'h1F;
    endfunction : want
    task automatic send(input int f, input logic [7:0] v);
        ebba_far_inst.evq[f].push_back(v);
        exq[f].push_back(want(compress_i[f/2], v));
    endtask : send
    task automatic mode(input logic [1:0] m);
        @(negedge mclk_i);
        compress_i = m;
        @(posedge mclk_i);
    endtask : mode
    // wait for all traffic to leave, then pair every increment with its event
    task automatic drain();
        int n;
        ebba_pkg::ebba_inc_t w;
        logic [7:0] e;
        n = 0;
        repeat (4) @(posedge mclk_i);
        while ((idle_o !== 2'b11 || evt_valid_i !== 4'h0) && n < 3000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 3000) miscompares++;
        @(posedge mclk_i);
        for (int t = 0; t < 2; t++) begin
            while (ebba_far_inst.got[t].size() > 0) begin
                w = ebba_far_inst.got[t].pop_front();
                e = exq[2*t+w.src].pop_front();
                `CHK(w.idx, e)
            end
        end
        for (int f = 0; f < 4; f++) `CHK(exq[f].size(), 0)
    endtask : drain
    task automatic s_full();
        mode(2'b00);
        for (int i = 0; i < 4; i++) begin
            send(0, 8'(i*85));
            send(1, 8'(255-i*85));
            send(3, 8'(i*85+1));
        end
        repeat (80) @(posedge mclk_i);
        for (int i = 0; i < 8; i++) `CHK(ebba_far_inst.got[0][i].src, i[0])
        drain();
    endtask : s_full
    task automatic s_bins();
        mode(2'b11);
        for (int v = 0; v < 256; v++) begin
            send(0, 8'(v));
            send(3, 8'(255-v));
        end
        drain();
    endtask : s_bins
    task automatic s_stall();
        mode(2'b01);
        stall <= 2'b11;
        for (int f = 0; f < 4; f++) begin
            for (int i = 0; i < 6; i++) send(f, 8'(f*60+i*40));
        end
        repeat (80) @(posedge mclk_i);
        @(negedge mclk_i);
        `CHK(inc_valid_o, 2'b11)
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk_i);
            stall <= {2{i[0]}};
        end
        stall <= 2'b00;
        drain();
    endtask : s_stall
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        end_sim();
    end
    initial begin
        nrst_i = 1'b0;
        compress_i = 2'b00;
        stall = 2'b00;
        miscompares = 0;
        compares = 0;
        repeat (16) @(negedge mclk_i);
        nrst_i = 1'b1;
        @(posedge mclk_i);
        s_full();
        s_bins();
        s_stall();
        end_sim();
    end
endmodule : tb_top
bind ebba_binning ebba_asserts ebba_asserts_inst (.mclk_i, .nrst_i, .compress_i, .evt_valid_i,
    .evt_ready_o, .inc_valid_o, .inc_data_o, .inc_ready_i, .idle_o);
